//--- src/droop_pkg.sv
// Operation
// RULE1 - decode six-bit AC load line code to tabulated resistance, 11h..3Fh monotonic
// RULE2 - droop value sets output voltage fall per ampere of output current
// RULE3 - droop command is a sixteen-bit linear word, read and written whole
// RULE4 - page 00h selects channel A, 01h channel B, FFh both at once
// RULE5 - bits 15:11 read back fixed exponent minus six, step 0.015625 milliohm
// RULE6 - bits 10:0 writable mantissa, power-up from non-volatile copy, listed codes only
// RULE7 - unlisted droop write is invalid data and leaves stored setting unchanged
// RULE8 - invalid droop write sets communication fault bits in both status words
// RULE9 - invalid droop write asserts the alert line to the host
// RULE10 - both channels accept D000h through D038h listed codes
// RULE11 - channel A accepts D039h and above listed codes, channel B rejects them
// RULE12 - AC load line code sits in bits 5:0 of loop compensation word
// RULE13 - both-channel droop write accepted only if valid for each channel
package droop_pkg;

  // ---------------------------------------------------------------
  // command codes and pages
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OUTPUT_DROOP_SLOPE = 8'h28;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_CML = 8'h7e;
  localparam logic [7:0] CMD_LOOP_COMP = 8'hd7;
  localparam logic [7:0] PAGE_A = 8'h00;
  localparam logic [7:0] PAGE_B = 8'h01;
  localparam logic [7:0] PAGE_ALL = 8'hff;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int MANT_W = 11;
  localparam int COMP_W = 14;
  localparam logic [4:0] DROOP_EXPONENT = 5'h1a;
  localparam int CML_INVALID_DATA_BIT = 6;
  localparam int STATUS_WORD_CML_BIT = 1;
  localparam int CHB_MAX_INDEX = 15; // last table entry that channel B still takes
  localparam logic [MANT_W-1:0] DROOP_RST = 11'h000;
  localparam logic [COMP_W-1:0] COMP_RST = 14'h0000;
  localparam logic [15:0] RDATA_RST = 16'h0000;

  // load line steps in 1/64 milliohm, shared by AC codes and droop mantissas
  localparam logic [7:0] LOAD_LINE_TABLE [0:63] = '{
    8'h00, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24,
    8'h28, 8'h30, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38,
    8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40,
    8'h41, 8'h42, 8'h43, 8'h44, 8'h48, 8'h50, 8'h58, 8'h60,
    8'h68, 8'h70, 8'h78, 8'h7c, 8'h80, 8'h84, 8'h88, 8'h8c,
    8'h90, 8'h98, 8'h9b, 8'h9c, 8'h9d, 8'h9e, 8'h9f, 8'ha0,
    8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8,
    8'ha9, 8'haa, 8'hab, 8'hac, 8'hb0, 8'hb8, 8'hc0, 8'hc8
  };

endpackage : droop_pkg

//--- src/load_line_droop_config.sv
`timescale 1ns/1ps
module load_line_droop_config
  import droop_pkg::*;
#(
  parameter int IOUT_W = 8
) (
  input wire logic sys_clk, // 200 MHz clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic clk_en, // freezes all state while low
  input wire logic cmd_wr, // write word strobe
  input wire logic cmd_rd, // read word strobe
  input wire logic [7:0] cmd_code, // command code
  input wire logic [7:0] cmd_page, // current page value
  input wire logic [15:0] cmd_wdata, // write word data
  output logic [15:0] cmd_rdata, // read word data
  output logic cmd_rvalid, // read data valid pulse
  input wire logic [MANT_W-1:0] nvm_droop_a, // stored droop mantissa, channel A
  input wire logic [MANT_W-1:0] nvm_droop_b, // stored droop mantissa, channel B
  input wire logic [COMP_W-1:0] nvm_comp_a, // stored compensation word, channel A
  input wire logic [COMP_W-1:0] nvm_comp_b, // stored compensation word, channel B
  input wire logic [IOUT_W-1:0] iout_a, // output current, channel A, amps
  input wire logic [IOUT_W-1:0] iout_b, // output current, channel B, amps
  output logic [MANT_W-1:0] dc_load_line_a, // droop slope A, 1/64 milliohm
  output logic [MANT_W-1:0] dc_load_line_b, // droop slope B, 1/64 milliohm
  output logic [7:0] ac_load_line_a, // AC load line A, 1/64 milliohm
  output logic [7:0] ac_load_line_b, // AC load line B, 1/64 milliohm
  output logic [IOUT_W+MANT_W-1:0] droop_offset_a, // voltage drop A, mV/64
  output logic [IOUT_W+MANT_W-1:0] droop_offset_b, // voltage drop B, mV/64
  output logic host_alert_line_out, // alert pin drive value, always low
  output logic host_alert_line_oe_n, // alert pin enable, low pulls the line
  input wire logic host_alert_line_in, // alert pin level as seen on the wire
  output logic alert_wire_low // synchronised: wire is pulled low by anyone
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // listed mantissa check; channel B stops at the lower table index
  function automatic logic droop_listed(input logic [15:0] w, input logic chb);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 64; i++) begin
      if (w[MANT_W-1:0] == {3'h0, LOAD_LINE_TABLE[i]} && (!chb || i <= CHB_MAX_INDEX)) begin
        hit = 1'b1;
      end
    end
    return hit && (w[15:11] == DROOP_EXPONENT);
  endfunction : droop_listed

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [MANT_W-1:0] droop_a_q, droop_a_d;
  logic [MANT_W-1:0] droop_b_q, droop_b_d;
  logic [COMP_W-1:0] comp_a_q, comp_a_d;
  logic [COMP_W-1:0] comp_b_q, comp_b_d;
  logic cml_invalid_q, cml_invalid_d;
  logic nvm_load_q, nvm_load_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic sel_a, sel_b, page_ok, droop_wr, droop_bad, bad_event;

  // page decode and validity of a droop write
  always_comb begin
    sel_a = (cmd_page == PAGE_A) || (cmd_page == PAGE_ALL); // RULE4
    sel_b = (cmd_page == PAGE_B) || (cmd_page == PAGE_ALL); // RULE4
    page_ok = sel_a || sel_b;
    droop_wr = cmd_wr && (cmd_code == CMD_OUTPUT_DROOP_SLOPE); // RULE3
    // both pages must accept a broadcast code
    droop_bad = !page_ok || (sel_a && !droop_listed(cmd_wdata, 1'b0)) // RULE10 RULE13
                || (sel_b && !droop_listed(cmd_wdata, 1'b1)); // RULE11 RULE13
    bad_event = droop_wr && droop_bad;
  end

  // next values of the configuration words
  always_comb begin
    droop_a_d = droop_a_q;
    droop_b_d = droop_b_q;
    comp_a_d = comp_a_q;
    comp_b_d = comp_b_q;
    nvm_load_d = 1'b0;
    if (nvm_load_q) begin
      // power-up copy from non-volatile store
      droop_a_d = nvm_droop_a; // RULE6
      droop_b_d = nvm_droop_b; // RULE6
      comp_a_d = nvm_comp_a;
      comp_b_d = nvm_comp_b;
    end else if (droop_wr && !droop_bad) begin
      if (sel_a) droop_a_d = cmd_wdata[MANT_W-1:0]; // RULE6
      if (sel_b) droop_b_d = cmd_wdata[MANT_W-1:0]; // RULE6
    end else if (cmd_wr && cmd_code == CMD_LOOP_COMP) begin
      if (sel_a) comp_a_d = cmd_wdata[COMP_W-1:0]; // RULE12
      if (sel_b) comp_b_d = cmd_wdata[COMP_W-1:0]; // RULE12
    end
  end

  // registers of the configuration words
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      droop_a_q <= DROOP_RST;
      droop_b_q <= DROOP_RST;
      comp_a_q <= COMP_RST;
      comp_b_q <= COMP_RST;
      nvm_load_q <= 1'b1;
    end else if (clk_en) begin
      droop_a_q <= droop_a_d;
      droop_b_q <= droop_b_d;
      comp_a_q <= comp_a_d;
      comp_b_q <= comp_b_d;
      nvm_load_q <= nvm_load_d;
    end
  end

  // ---------------------------------------------------------------
  // fault flag: set on rejected data, cleared by clear-faults
  // ---------------------------------------------------------------
  always_comb begin
    cml_invalid_d = cml_invalid_q;
    if (cmd_wr && cmd_code == CMD_CLEAR_FAULTS) cml_invalid_d = 1'b0;
    if (cmd_wr && cmd_code == CMD_STATUS_CML && cmd_wdata[CML_INVALID_DATA_BIT]) cml_invalid_d = 1'b0;
    if (bad_event) cml_invalid_d = 1'b1; // RULE7 RULE8
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cml_invalid_q <= 1'b0;
    end else if (clk_en) begin
      cml_invalid_q <= cml_invalid_d;
    end
  end

  // ---------------------------------------------------------------
  // read word path
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = RDATA_RST;
    rvalid_d = cmd_rd;
    case (cmd_code)
      CMD_OUTPUT_DROOP_SLOPE: begin
        // broadcast page reads back channel A
        rdata_d = {DROOP_EXPONENT, (cmd_page == PAGE_B) ? droop_b_q : droop_a_q}; // RULE5 RULE3
      end
      CMD_LOOP_COMP: begin
        rdata_d = {2'h0, (cmd_page == PAGE_B) ? comp_b_q : comp_a_q};
      end
      CMD_STATUS_CML: begin
        rdata_d[CML_INVALID_DATA_BIT] = cml_invalid_q; // RULE8
      end
      CMD_STATUS_WORD: begin
        rdata_d[STATUS_WORD_CML_BIT] = cml_invalid_q; // RULE8
      end
      default: begin
        rdata_d = RDATA_RST;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= RDATA_RST;
      rvalid_q <= 1'b0;
    end else if (clk_en) begin
      rvalid_q <= rvalid_d;
      if (cmd_rd) rdata_q <= rdata_d;
    end
  end

  assign cmd_rdata = rdata_q;
  assign cmd_rvalid = rvalid_q;

  // ---------------------------------------------------------------
  // load line outputs and droop offset
  // ---------------------------------------------------------------
  logic [7:0] ac_a_q, ac_a_d, ac_b_q, ac_b_d;
  logic [IOUT_W+MANT_W-1:0] off_a_q, off_a_d, off_b_q, off_b_d;

  // AC code lookup and current times slope
  always_comb begin
    ac_a_d = LOAD_LINE_TABLE[comp_a_q[5:0]]; // RULE1 RULE12
    ac_b_d = LOAD_LINE_TABLE[comp_b_q[5:0]]; // RULE1 RULE12
    off_a_d = iout_a * droop_a_q; // RULE2
    off_b_d = iout_b * droop_b_q; // RULE2
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ac_a_q <= 8'h00;
      ac_b_q <= 8'h00;
      off_a_q <= '0;
      off_b_q <= '0;
    end else if (clk_en) begin
      ac_a_q <= ac_a_d;
      ac_b_q <= ac_b_d;
      off_a_q <= off_a_d;
      off_b_q <= off_b_d;
    end
  end

  assign ac_load_line_a = ac_a_q;
  assign ac_load_line_b = ac_b_q;
  assign droop_offset_a = off_a_q;
  assign droop_offset_b = off_b_q;
  assign dc_load_line_a = droop_a_q;
  assign dc_load_line_b = droop_b_q;

  // ---------------------------------------------------------------
  // alert pin and its wire level
  // ---------------------------------------------------------------
  logic wire_s1_q, wire_s2_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wire_s1_q <= 1'b1;
      wire_s2_q <= 1'b1;
    end else if (clk_en) begin
      wire_s1_q <= host_alert_line_in;
      wire_s2_q <= wire_s1_q;
    end
  end

  assign host_alert_line_out = 1'b0;
  assign host_alert_line_oe_n = !cml_invalid_q; // RULE9
  assign alert_wire_low = !wire_s2_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  exp_readback_a: assert property (clk_en && cmd_rd && cmd_code == CMD_OUTPUT_DROOP_SLOPE // RULE5
    |=> cmd_rvalid && cmd_rdata[15:11] == DROOP_EXPONENT)
    else $error("droop exponent not read back");
  invalid_keeps_a: assert property (clk_en && !nvm_load_q && bad_event // RULE7
    |=> $stable(dc_load_line_a) && $stable(dc_load_line_b))
    else $error("rejected droop write changed setting");
  invalid_flag_a: assert property (clk_en && bad_event // RULE8
    |=> cml_invalid_q)
    else $error("invalid data flag not set");
  freeze_hold_a: assert property (!clk_en // RULE6
    |=> $stable(dc_load_line_a) && $stable(dc_load_line_b) && $stable(host_alert_line_oe_n))
    else $error("state moved while clock enable low");
  alert_drive_a: assert property (clk_en && bad_event // RULE9
    |=> !host_alert_line_oe_n && !host_alert_line_out)
    else $error("alert not driven after rejected write");
  chb_reject_a: assert property (clk_en && !nvm_load_q && cmd_wr && cmd_code == CMD_OUTPUT_DROOP_SLOPE // RULE11
    && cmd_page == PAGE_B && cmd_wdata == 16'hd039 |=> cml_invalid_q && $stable(dc_load_line_b))
    else $error("channel B took code above its range");
  valid_store_a: assert property (clk_en && !nvm_load_q && droop_wr && !droop_bad && sel_a // RULE10
    |=> dc_load_line_a == $past(cmd_wdata[MANT_W-1:0]))
    else $error("listed droop code not stored");
  ac_decode_a: assert property (clk_en && !nvm_load_q && cmd_wr && cmd_code == CMD_LOOP_COMP // RULE1
    && cmd_page == PAGE_A && cmd_wdata[5:0] == 6'h3f ##1 clk_en |=> ac_load_line_a == 8'hc8)
    else $error("AC code 3Fh not decoded");
  broadcast_a: assert property (clk_en && !nvm_load_q && droop_wr && cmd_page == PAGE_ALL // RULE13
    && !droop_listed(cmd_wdata, 1'b1) |=> $stable(dc_load_line_a) && cml_invalid_q)
    else $error("broadcast write taken despite channel B");
  offset_calc_a: assert property (clk_en // RULE2
    |=> droop_offset_a == $past(iout_a) * $past(dc_load_line_a))
    else $error("droop offset wrong");

  bad_write_c: cover property (clk_en && bad_event);
  broadcast_ok_c: cover property (clk_en && droop_wr && !droop_bad && cmd_page == PAGE_ALL);
  status_read_c: cover property (clk_en && cmd_rd && cmd_code == CMD_STATUS_WORD && cml_invalid_q);
  frozen_write_c: cover property (!clk_en && droop_wr);

endmodule : load_line_droop_config

//--- tb/alert_host_model.sv
`timescale 1ns/1ps
// -------------------------------------------------
// host side of the open-drain alert wire
// -------------------------------------------------
module alert_host_model (
  input wire logic oe_n, // device enable, low pulls the wire
  input wire logic drv, // device drive value
  output logic wire_lvl // resolved wire level seen by everyone
);
  // pull-up wins unless the device enables its low drive
  assign wire_lvl = (!oe_n && !drv) ? 1'b0 : 1'b1;
endmodule : alert_host_model

//--- tb/tb_load_line_droop_config.sv
`timescale 1ns/1ps
module tb_load_line_droop_config;
  import droop_pkg::*;
  logic sys_clk, sys_rst, clk_en, cmd_wr, cmd_rd, cmd_rvalid, a_out, a_oe_n, a_lvl, a_low;
  logic [7:0] cmd_code, cmd_page, iout_a, iout_b, ac_a, ac_b;
  logic [15:0] cmd_wdata, cmd_rdata;
  logic [MANT_W-1:0] dc_a, dc_b, old_a, old_b;
  logic [18:0] off_a, off_b;
  int error_cnt = 0;
  int n_compared = 0;
  logic [23:0] bad [0:5] = '{24'h01d039, 24'h01d0c8, 24'h00d001, 24'h000038, 24'hffd039, 24'h02d010};

  load_line_droop_config #(.IOUT_W(8)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .nvm_droop_a(11'h038), .nvm_droop_b(11'h014),
    .nvm_comp_a(14'h0029), .nvm_comp_b(14'h0000), .iout_a(iout_a), .iout_b(iout_b),
    .dc_load_line_a(dc_a), .dc_load_line_b(dc_b), .ac_load_line_a(ac_a), .ac_load_line_b(ac_b),
    .droop_offset_a(off_a), .droop_offset_b(off_b), .host_alert_line_out(a_out),
    .host_alert_line_oe_n(a_oe_n), .host_alert_line_in(a_lvl), .alert_wire_low(a_low));
  alert_host_model host (.oe_n(a_oe_n), .drv(a_out), .wire_lvl(a_lvl));

  // -------------------------------------------------
  // shared tasks
  // -------------------------------------------------
  task automatic check(input logic [18:0] got, input logic [18:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : check

  // lowers the strobes, then lets n edges pass
  task automatic tick(input int n);
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // one request taken at the next edge; strobes stay up until the next request or tick
  task automatic req(input logic wr, input logic [7:0] code, input logic [7:0] page, input logic [15:0] d);
    cmd_wr = wr;
    cmd_rd = !wr;
    cmd_code = code;
    cmd_page = page;
    cmd_wdata = d;
    @(posedge sys_clk);
    #1;
  endtask : req

  task automatic rd(input logic [7:0] code, input logic [7:0] page, input logic [15:0] exp);
    req(1'b0, code, page, 16'h0000);
    check(cmd_rvalid, 1'b1);
    check(cmd_rdata, exp);
    tick(1);
    check(cmd_rvalid, 1'b0);
  endtask : rd

  // fault flag in both status words, alert enable and synced wire
  task automatic flt(input logic exp);
    req(1'b0, CMD_STATUS_CML, PAGE_A, 16'h0000);
    check(cmd_rdata[CML_INVALID_DATA_BIT], exp);
    req(1'b0, CMD_STATUS_WORD, PAGE_A, 16'h0000);
    check(cmd_rdata[STATUS_WORD_CML_BIT], exp);
    check(a_oe_n, !exp);
    tick(2);
    check(a_low, exp);
  endtask : flt

  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  task automatic s_reset;
    check(dc_a, 11'h038);
    check(dc_b, 11'h014);
    check(ac_a, 8'h98);
    rd(CMD_OUTPUT_DROOP_SLOPE, PAGE_A, 16'hd038);
    rd(CMD_OUTPUT_DROOP_SLOPE, PAGE_B, 16'hd014);
    flt(1'b0);
  endtask : s_reset

  task automatic s_accept;
    req(1'b1, CMD_OUTPUT_DROOP_SLOPE, PAGE_B, 16'hd000);
    check(dc_b, 11'h000);
    req(1'b1, CMD_OUTPUT_DROOP_SLOPE, PAGE_B, 16'hd038);
    rd(CMD_OUTPUT_DROOP_SLOPE, PAGE_B, 16'hd038);
    req(1'b1, CMD_OUTPUT_DROOP_SLOPE, PAGE_A, 16'hd039);
    check(dc_a, 11'h039);
    req(1'b1, CMD_OUTPUT_DROOP_SLOPE, PAGE_A, 16'hd0c8);
    rd(CMD_OUTPUT_DROOP_SLOPE, PAGE_A, 16'hd0c8);
    flt(1'b0);
  endtask : s_accept

  // refused writes: channel B limit, unlisted, bad exponent, broadcast, bad page
  task automatic s_reject;
    for (int i = 0; i < 6; i++) begin
      old_a = dc_a;
      old_b = dc_b;
      req(1'b1, CMD_OUTPUT_DROOP_SLOPE, bad[i][23:16], bad[i][15:0]);
      tick(1);
      check(dc_a, old_a);
      check(dc_b, old_b);
      flt(1'b1);
      // alternate clear-faults and a status write with the invalid-data bit set
      req(1'b1, (i % 2) ? CMD_STATUS_CML : CMD_CLEAR_FAULTS, PAGE_A, 16'h0040);
      flt(1'b0);
    end
  endtask : s_reject

  task automatic s_broadcast;
    req(1'b1, CMD_OUTPUT_DROOP_SLOPE, PAGE_ALL, 16'hd010);
    check(dc_a, 11'h010);
    check(dc_b, 11'h010);
  endtask : s_broadcast

  // clock enable low: requests are not taken and nothing moves
  task automatic s_freeze;
    clk_en = 1'b0;
    req(1'b1, CMD_OUTPUT_DROOP_SLOPE, PAGE_A, 16'hd000);
    check(dc_a, 11'h010);
    req(1'b0, CMD_OUTPUT_DROOP_SLOPE, PAGE_B, 16'h0000);
    check(cmd_rvalid, 1'b0);
    req(1'b1, CMD_OUTPUT_DROOP_SLOPE, PAGE_B, 16'hd039);
    check(a_oe_n, 1'b1);
    tick(1);
    clk_en = 1'b1;
    check(dc_a, 11'h010);
    flt(1'b0);
  endtask : s_freeze

  task automatic s_ac;
    req(1'b1, CMD_LOOP_COMP, PAGE_A, 16'h0011);
    req(1'b1, CMD_LOOP_COMP, PAGE_B, 16'h3f3f);
    check(ac_a, 8'h3a);
    tick(1);
    check(ac_b, 8'hc8);
    rd(CMD_LOOP_COMP, PAGE_B, 16'h3f3f);
    req(1'b1, CMD_LOOP_COMP, PAGE_A, 16'h003f);
    tick(1);
    check(ac_a, 8'hc8);
  endtask : s_ac

  task automatic s_offset;
    iout_a = 8'd10;
    iout_b = 8'hff;
    tick(2);
    check(off_a, 19'd160);
    check(off_b, 19'd4080);
  endtask : s_offset

  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // -------------------------------------------------
  // clock and main sequence
  // -------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    {cmd_code, cmd_page, cmd_wdata, iout_a, iout_b} = '0;
    tick(5);
    sys_rst = 1'b0;
    tick(2);
    s_reset();
    s_accept();
    s_reject();
    s_broadcast();
    s_freeze();
    s_ac();
    s_offset();
    wrap_up();
  end
endmodule : tb_load_line_droop_config
